/* File: hdc_top.sv */
// register front end of the two link controllers: address filter and fifo port
// Notes on behaviour
// - two identical controllers, each with its own register set in its own page
// - first address register bits 7..2 mask the first received address byte
// - bit 1 joins the first-byte compare only when the seven-bit option is set
// - first-byte mask used only while its enable bit 0 is high
// - with filtering on, packets failing the compare never reach the receive fifo
// - all-ones all-call address recognised only with first enable high
// - second address register bits 7..1 mask the second received address byte
// - all-call address overrides both masks
// - second mask used only while its bit 0 is set; all-call needs it set
// - each fifo write pushes byte plus end and abort tags as ten bits
// - fifo status shown to the host lags pointer changes by one cycle
// - fifo offset read returns next received byte; its status in status register
// - eight interrupt sources, writable mask and matching read-only status bits
// - status holds interrupt flag, idle flag, byte status, tx and rx state
// - control one bit 7 enables address filtering
// - end tag marks last byte before check sequence; cleared after each fifo write
// - abort tag aborts the packet; cleared after each fifo write
// - byte status: 00 body, 01 first, 10 good last, 11 bad last
`timescale 1ns/1ns
`default_nettype none
module hdc_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_page,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [hdc_pkg::NCH-1:0] i_rx_valid,
  input wire logic [hdc_pkg::NCH*8-1:0] i_rx_data,
  input wire logic [hdc_pkg::NCH-1:0] i_rx_sop,
  input wire logic [hdc_pkg::NCH-1:0] i_rx_eop,
  input wire logic [hdc_pkg::NCH-1:0] i_rx_bad,
  input wire logic [hdc_pkg::NCH*16-1:0] i_rx_crc,
  input wire logic [hdc_pkg::NCH-1:0] i_idle_chan,
  input wire logic [hdc_pkg::NCH-1:0] i_go_ahead,
  input wire logic [hdc_pkg::NCH-1:0] i_tx_underrun,
  input wire logic [hdc_pkg::NCH-1:0] i_tx_ready,
  output logic [hdc_pkg::NCH-1:0] o_tx_valid,
  output logic [hdc_pkg::NCH*8-1:0] o_tx_data,
  output logic [hdc_pkg::NCH-1:0] o_tx_eop,
  output logic [hdc_pkg::NCH-1:0] o_tx_abort,
  output logic [hdc_pkg::NCH-1:0] o_tx_mark_idle
);
  import hdc_pkg::*;

  logic [7:0] rdw [NCH];
  logic [NCH-1:0] rd_hit;
  logic [7:0] rdata_d, rdata_q;

  // a strobe belongs to a channel when its page matches
  function automatic logic page_hit(input logic [7:0] pg, input int c);
    return (pg == ((c == 0) ? PAGE_FIRST : PAGE_SECOND));
  endfunction : page_hit

  // host-writable offsets; the write and read decoders must agree on this list
  function automatic logic is_cfg(input logic [4:0] a);
    return (a == A_ADR1 || a == A_ADR2 || a == A_CTL1 || a == A_CTL2 || a == A_IMSK || a == A_TBC ||
            a == A_TCTL || a == A_CTL3 || a == A_CTL4);
  endfunction : is_cfg

  // address match: masks, enables, seven-bit option and all-call
  function automatic logic addr_ok(input logic [7:0] m1, input logic [7:0] m2,
                                   input logic [7:0] b1, input logic [7:0] b2,
                                   input logic seven);
    logic m1_ok;
    logic m2_ok;
    logic all_call;
    m1_ok = (b1[7:2] == m1[7:2]);
    if (seven) begin
      m1_ok = m1_ok & (b1[B_XBIT] == m1[B_XBIT]);
    end
    m2_ok = (b2[7:1] == m2[7:1]);
    all_call = m1[B_MEN] & m2[B_MEN] & (b1[7:1] == ALL_CALL);
    return all_call | ((!m1[B_MEN] | m1_ok) & (!m2[B_MEN] | m2_ok));
  endfunction : addr_ok

  // one identical controller per page
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_c, rd_c;
    logic [7:0] cfg_q [16];
    logic [7:0] cfg_d [16];
    logic [7:0] adr1, adr2, ctl1, ctl2, imask;
    logic txf_push, txf_rdy, txf_v, txf_pop;
    logic [ENTRY_W-1:0] txf_data;
    logic [ENTRY_W-1:0] txf_out;
    logic [CNT_W-1:0] txf_cnt;
    logic rxf_push, rxf_rdy, rxf_v, rxf_pop;
    logic [ENTRY_W-1:0] rxf_wdata, rxf_data;
    logic [CNT_W-1:0] rxf_cnt;
    hdc_flt_t st_q, st_d;
    logic [ENTRY_W-1:0] b1_q, b1_d, pend_q, pend_d;
    logic pend_v_q, pend_v_d, vaddr_q, vaddr_d;
    logic ovf_ev;
    logic [ENTRY_W-1:0] rx_entry;
    logic txo_v_q, txo_v_d;
    logic [ENTRY_W-1:0] txo_q, txo_d;
    logic txo_done;
    logic [CNT_W-1:0] txcnt_q, rxcnt_q;
    logic [1:0] rq_q;
    logic idle_q, tx_low_q, rx_full_q;
    logic [7:0] ist_q, ist_d, ev;
    logic intgen_q, intgen_d;

    assign wr_c = i_cs & i_wr & page_hit(i_page, c);
    assign rd_c = i_cs & i_rd & page_hit(i_page, c);
    assign rd_hit[c] = rd_c;
    assign adr1 = cfg_q[A_ADR1[3:0]];
    assign adr2 = cfg_q[A_ADR2[3:0]];
    assign ctl1 = cfg_q[A_CTL1[3:0]];
    assign ctl2 = cfg_q[A_CTL2[3:0]];
    assign imask = cfg_q[A_IMSK[3:0]];

    // host writes to the writable registers and the transmit fifo port
    always_comb begin
      cfg_d = cfg_q;
      txf_push = 1'b0;
      if (wr_c) begin
        if (i_addr == A_FIFO) begin
          txf_push = 1'b1;
          cfg_d[A_CTL1[3:0]][B_EOP] = 1'b0;
          cfg_d[A_CTL1[3:0]][B_FA] = 1'b0;
        end else if (is_cfg(i_addr)) begin
          cfg_d[i_addr[3:0]] = i_wdata;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        for (int k = 0; k < 16; k++) begin
          cfg_q[k] <= RST_REG;
        end
      end else begin
        cfg_q <= cfg_d;
      end
    end

    // a full transmit fifo refuses the byte; the tags are still consumed
    assign txf_data = {ctl1[B_FA], ctl1[B_EOP], i_wdata};

    hdc_fifo #(
      .W(ENTRY_W),
      .D(FIFO_DEPTH)
    ) u_txf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(txf_push),
      .o_ready(txf_rdy),
      .i_data(txf_data),
      .o_valid(txf_v),
      .i_ready(txf_pop),
      .o_data(txf_out),
      .o_count(txf_cnt)
    );

    hdc_fifo #(
      .W(ENTRY_W),
      .D(FIFO_DEPTH)
    ) u_rxf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(rxf_push),
      .o_ready(rxf_rdy),
      .i_data(rxf_wdata),
      .o_valid(rxf_v),
      .i_ready(rxf_pop),
      .o_data(rxf_data),
      .o_count(rxf_cnt)
    );

    // transmit output stage keeps the link outputs on flops; stalls on link ready
    always_comb begin
      txo_done = txo_v_q & i_tx_ready[c];
      txf_pop = txf_v & ctl1[B_TXEN] & (!txo_v_q | i_tx_ready[c]);
      txo_v_d = txo_v_q & !txo_done;
      txo_d = txo_q;
      if (txf_pop) begin
        txo_v_d = 1'b1;
        txo_d = txf_out;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        txo_v_q <= 1'b0;
        txo_q <= '0;
      end else begin
        txo_v_q <= txo_v_d;
        txo_q <= txo_d;
      end
    end

    assign o_tx_valid[c] = txo_v_q;
    assign o_tx_data[c*8 +: 8] = txo_q[7:0];
    assign o_tx_eop[c] = txo_q[8];
    assign o_tx_abort[c] = txo_q[9];
    assign o_tx_mark_idle[c] = ctl1[B_MIDLE];

    // receive filter: hold the first byte, decide on the second
    always_comb begin
      st_d = st_q;
      b1_d = b1_q;
      pend_d = pend_q;
      pend_v_d = 1'b0;
      vaddr_d = vaddr_q;
      rxf_push = 1'b0;
      rxf_wdata = pend_q;
      rx_entry = {RQ_BODY, i_rx_data[c*8 +: 8]};
      if (i_rx_eop[c]) begin
        rx_entry[9:8] = i_rx_bad[c] ? RQ_BAD : RQ_GOOD;
      end else if (i_rx_sop[c]) begin
        rx_entry[9:8] = RQ_FIRST;
      end
      if (pend_v_q) begin
        rxf_push = 1'b1;
      end
      if (i_rx_valid[c] && ctl1[B_RXEN]) begin
        if (i_rx_sop[c]) begin
          if (ctl1[B_ADREC]) begin
            b1_d = rx_entry;
            st_d = i_rx_eop[c] ? FLT_IDLE : FLT_SECOND;
          end else begin
            rxf_push = 1'b1;
            rxf_wdata = rx_entry;
            st_d = i_rx_eop[c] ? FLT_IDLE : FLT_PASS;
          end
        end else begin
          case (st_q)
            FLT_SECOND: begin
              vaddr_d = addr_ok(adr1, adr2, b1_q[7:0], i_rx_data[c*8 +: 8], ctl2[B_SEVEN]);
              if (vaddr_d) begin
                rxf_push = 1'b1;
                rxf_wdata = b1_q;
                pend_d = rx_entry;
                pend_v_d = 1'b1;
                st_d = i_rx_eop[c] ? FLT_IDLE : FLT_PASS;
              end else begin
                st_d = i_rx_eop[c] ? FLT_IDLE : FLT_DROP;
              end
            end
            FLT_PASS: begin
              rxf_push = 1'b1;
              rxf_wdata = rx_entry;
              if (i_rx_eop[c]) begin
                st_d = FLT_IDLE;
              end
            end
            FLT_DROP: begin
              if (i_rx_eop[c]) begin
                st_d = FLT_IDLE;
              end
            end
            default: begin
              st_d = FLT_IDLE;
            end
          endcase
        end
      end
      ovf_ev = rxf_push & !rxf_rdy;
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        st_q <= FLT_IDLE;
        b1_q <= '0;
        pend_q <= '0;
        pend_v_q <= 1'b0;
        vaddr_q <= 1'b0;
      end else begin
        st_q <= st_d;
        b1_q <= b1_d;
        pend_q <= pend_d;
        pend_v_q <= pend_v_d;
        vaddr_q <= vaddr_d;
      end
    end

    assign rxf_pop = rd_c & (i_addr == A_FIFO) & rxf_v;

    // status snapshot one cycle behind the fifo pointers, so it reads settled
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        txcnt_q <= '0;
        rxcnt_q <= '0;
        rq_q <= RQ_BODY;
        idle_q <= 1'b0;
        tx_low_q <= 1'b1;
        rx_full_q <= 1'b0;
      end else begin
        txcnt_q <= txf_cnt;
        rxcnt_q <= rxf_cnt;
        rq_q <= rxf_v ? rxf_data[9:8] : RQ_BODY;
        idle_q <= i_idle_chan[c];
        tx_low_q <= (txcnt_q <= TX_LOW_MARK);
        rx_full_q <= (rxcnt_q == FULL_CNT);
      end
    end

    // sticky sources, cleared by reading the interrupt status; a new event wins
    always_comb begin
      ev = '0;
      ev[IB_GA] = i_go_ahead[c];
      ev[IB_PACKET_END_DETECTED_EVENT] = rxf_push & rxf_rdy & rxf_wdata[9];
      ev[IB_TX_PACKET_END_EVENT] = txo_done & txo_q[8];
      ev[IB_PACKET_END_READ_EVENT] = rxf_pop & rxf_data[9];
      ev[IB_TX_FIFO_LOW_EVENT] = (txcnt_q <= TX_LOW_MARK) & !tx_low_q;
      ev[IB_ABUN] = (txo_done & txo_q[9]) | i_tx_underrun[c];
      ev[IB_RX_FIFO_FULL_EVENT] = (rxcnt_q == FULL_CNT) & !rx_full_q;
      ev[IB_OVF] = ovf_ev;
      ist_d = ist_q;
      intgen_d = intgen_q;
      if (rd_c && i_addr == A_ISTA) begin
        ist_d = '0;
        intgen_d = 1'b0;
      end
      ist_d = ist_d | ev;
      intgen_d = intgen_d | (|(ev & imask));
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        ist_q <= '0;
        intgen_q <= 1'b0;
      end else begin
        ist_q <= ist_d;
        intgen_q <= intgen_d;
      end
    end

    // read word of this channel
    always_comb begin
      if (i_addr == A_FIFO) begin
        rdw[c] = rxf_data[7:0];
      end else if (i_addr == A_STAT) begin
        rdw[c] = {intgen_q, idle_q, rq_q, txcnt_q == FULL_CNT, txcnt_q == '0,
                  rxcnt_q == FULL_CNT, rxcnt_q == '0};
      end else if (i_addr == A_ISTA) begin
        rdw[c] = ist_q;
      end else if (i_addr == A_CRCH) begin
        rdw[c] = i_rx_crc[c*16+8 +: 8];
      end else if (i_addr == A_CRCL) begin
        rdw[c] = i_rx_crc[c*16 +: 8];
      end else if (i_addr == A_TSTA) begin
        rdw[c] = {7'h00, vaddr_q};
      end else if (is_cfg(i_addr)) begin
        rdw[c] = cfg_q[i_addr[3:0]];
      end else begin
        rdw[c] = 8'h00;
      end
    end
  end

  // read data registered on the strobe, held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd_hit[0]) begin
      rdata_d = rdw[0];
    end else if (rd_hit[1]) begin
      rdata_d = rdw[1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
endmodule : hdc_top
`default_nettype wire

/* File: hdc_pkg.sv */
// constants and types shared by the link controller front end
`default_nettype none
package hdc_pkg;
  // two identical controllers, one per register page
  localparam int NCH = 2;
  localparam logic [7:0] PAGE_FIRST = 8'h0b;
  localparam logic [7:0] PAGE_SECOND = 8'h0c;
  // register offsets within a page
  localparam logic [4:0] A_ADR1 = 5'h10;
  localparam logic [4:0] A_ADR2 = 5'h11;
  localparam logic [4:0] A_FIFO = 5'h12;
  localparam logic [4:0] A_CTL1 = 5'h13;
  localparam logic [4:0] A_STAT = 5'h14;
  localparam logic [4:0] A_CTL2 = 5'h15;
  localparam logic [4:0] A_IMSK = 5'h16;
  localparam logic [4:0] A_ISTA = 5'h17;
  localparam logic [4:0] A_CRCH = 5'h18;
  localparam logic [4:0] A_CRCL = 5'h19;
  localparam logic [4:0] A_TBC = 5'h1a;
  localparam logic [4:0] A_TCTL = 5'h1b;
  localparam logic [4:0] A_TSTA = 5'h1c;
  localparam logic [4:0] A_CTL3 = 5'h1d;
  localparam logic [4:0] A_CTL4 = 5'h1e;
  localparam logic [7:0] RST_REG = 8'h00;
  // field positions
  localparam int B_ADREC = 7;
  localparam int B_RXEN = 6;
  localparam int B_TXEN = 5;
  localparam int B_EOP = 4;
  localparam int B_FA = 3;
  localparam int B_MIDLE = 2;
  localparam int B_SEVEN = 4;
  localparam int B_MEN = 0;
  localparam int B_XBIT = 1;
  // interrupt source positions
  localparam int IB_GA = 7;
  localparam int IB_PACKET_END_DETECTED_EVENT = 6;
  localparam int IB_TX_PACKET_END_EVENT = 5;
  localparam int IB_PACKET_END_READ_EVENT = 4;
  localparam int IB_TX_FIFO_LOW_EVENT = 3;
  localparam int IB_ABUN = 2;
  localparam int IB_RX_FIFO_FULL_EVENT = 1;
  localparam int IB_OVF = 0;
  localparam logic [6:0] ALL_CALL = 7'h7f;
  // receive byte status codes
  localparam logic [1:0] RQ_BODY = 2'h0;
  localparam logic [1:0] RQ_FIRST = 2'h1;
  localparam logic [1:0] RQ_GOOD = 2'h2;
  localparam logic [1:0] RQ_BAD = 2'h3;
  localparam int FIFO_DEPTH = 8;
  localparam int ENTRY_W = 10;
  localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] TX_LOW_MARK = CNT_W'(2);
  typedef enum logic [1:0] {FLT_IDLE, FLT_SECOND, FLT_PASS, FLT_DROP} hdc_flt_t;
endpackage : hdc_pkg
`default_nettype wire

/* File: hdc_fifo.sv */
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module hdc_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // full and empty from the pointer distance, so back-pressure is exact
  always_comb begin
    o_count = wr_q - rd_q;
    o_ready = (o_count != (AW+1)'(D));
    o_valid = (wr_q != rd_q);
    o_data = mem_q[rd_q[AW-1:0]];
    push = i_valid & o_ready;
    pop = o_valid & i_ready;
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_data;
    end
  end
endmodule : hdc_fifo
`default_nettype wire

/* File: hdc_top_assertions.sv */
// port-level concurrent checks for the link controller front end
`timescale 1ns/1ns
`default_nettype none
module hdc_top_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_page,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [hdc_pkg::NCH*16-1:0] i_rx_crc,
  input wire logic [hdc_pkg::NCH-1:0] i_tx_ready,
  input wire logic [hdc_pkg::NCH-1:0] o_tx_valid,
  input wire logic [hdc_pkg::NCH*8-1:0] o_tx_data,
  input wire logic [hdc_pkg::NCH-1:0] o_tx_eop,
  input wire logic [hdc_pkg::NCH-1:0] o_tx_mark_idle
);
  import hdc_pkg::*;
  logic rd_ok;
  logic wr_ctl;
  // accepted read on a valid page, or control write on any page
  assign rd_ok = i_cs && i_rd && (i_page == PAGE_FIRST || i_page == PAGE_SECOND);
  assign wr_ctl = i_cs && i_wr && i_addr == A_CTL1;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // first edge after release must already see cleared outputs
  reset_clear_a: assert property (disable iff (1'b0) $fell(i_rst) |-> o_rdata == 8'h00 && o_tx_valid == 2'b00)
    else $error("outputs not cleared by reset");
  rdata_hold_a: assert property (!rd_ok |=> $stable(o_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd_ok && (i_addr < A_ADR1 || i_addr == 5'h1f) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  crc_first_a: assert property (rd_ok && i_page == PAGE_FIRST && i_addr == A_CRCH |=> o_rdata == $past(i_rx_crc[15:8]))
    else $error("first page check high byte wrong");
  crc_second_a: assert property (rd_ok && i_page == PAGE_SECOND && i_addr == A_CRCH |=> o_rdata == $past(i_rx_crc[31:24]))
    else $error("second page check high byte wrong");
  // a stalled tx byte and its tag must not move
  tx_hold_a: assert property (o_tx_valid[0] && !i_tx_ready[0] |=> o_tx_valid[0] && $stable(o_tx_data[7:0]) && $stable(o_tx_eop[0]))
    else $error("stalled tx byte changed");
  idle_follow_a: assert property (wr_ctl && i_page == PAGE_FIRST |=> o_tx_mark_idle[0] == $past(i_wdata[B_MIDLE]))
    else $error("mark idle not following control write");
  idle_page_a: assert property (wr_ctl && i_page == PAGE_FIRST |=> $stable(o_tx_mark_idle[1]))
    else $error("first page write reached second controller");
endmodule : hdc_top_assertions
bind hdc_top hdc_top_assertions u_chk (.i_clk, .i_rst, .i_cs, .i_rd, .i_wr, .i_page, .i_addr, .i_wdata, .o_rdata,
  .i_rx_crc, .i_tx_ready, .o_tx_valid, .o_tx_data, .o_tx_eop, .o_tx_mark_idle);
`default_nettype wire

/* File: hdc_link_model.sv */
// far side of one link: takes tx bytes with a slow ready, sends rx bytes on request
`timescale 1ns/1ns
`default_nettype none
module hdc_link_model (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_eop,
  input wire logic i_tx_abort,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_sop,
  output logic o_rx_eop,
  output logic o_rx_bad
);
  logic [9:0] got [$];
  logic [1:0] tick = 2'h0;
  logic rdy_q = 1'b1;
  assign o_tx_ready = rdy_q;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_sop = 1'b0;
    o_rx_eop = 1'b0;
    o_rx_bad = 1'b0;
  end
  // ready one cycle in four so the tx stage must hold its byte
  always @(negedge i_clk) begin
    tick <= tick + 2'h1;
    rdy_q <= tick == 2'h0;
  end
  // capture each taken byte with its tags
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) got.push_back({i_tx_abort, i_tx_eop, i_tx_data});
  end
  // one received byte; the data line is scrambled once it is no longer valid
  task automatic send(input logic [7:0] d, input logic s, input logic e, input logic b);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_data = d;
    o_rx_sop = s;
    o_rx_eop = e;
    o_rx_bad = b;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~d;
  endtask : send
endmodule : hdc_link_model
`default_nettype wire

/* File: tb.sv */
// testbench: register access, tx fifo path and rx address filter
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  import hdc_pkg::*;
  logic i_clk = 0, i_rst = 1, i_cs = 0, i_rd = 0, i_wr = 0;
  logic [7:0] i_page = 0, i_wdata = 0, o_rdata, v;
  logic [4:0] i_addr = 0;
  logic [1:0] rxv, rxs, rxe, rxb, txr, txv, txe, txa, o_mi, idl = 0, ga = 0, und = 0;
  logic [15:0] rxd, txd;
  logic [4:0] ra [6] = '{A_ADR1, A_ADR2, A_IMSK, A_TBC, A_CTL3, A_CTL4};
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  hdc_top u_dut (.i_clk, .i_rst, .i_cs, .i_rd, .i_wr, .i_page, .i_addr, .i_wdata, .o_rdata, .i_rx_valid(rxv),
    .i_rx_data(rxd), .i_rx_sop(rxs), .i_rx_eop(rxe), .i_rx_bad(rxb), .i_rx_crc(32'h1234abcd), .i_idle_chan(idl),
    .i_go_ahead(ga), .i_tx_underrun(und), .i_tx_ready(txr), .o_tx_valid(txv), .o_tx_data(txd), .o_tx_eop(txe),
    .o_tx_abort(txa), .o_tx_mark_idle(o_mi));
  hdc_link_model u_l0 (.i_clk, .i_tx_valid(txv[0]), .i_tx_data(txd[7:0]), .i_tx_eop(txe[0]), .i_tx_abort(txa[0]),
    .o_tx_ready(txr[0]), .o_rx_valid(rxv[0]), .o_rx_data(rxd[7:0]), .o_rx_sop(rxs[0]), .o_rx_eop(rxe[0]),
    .o_rx_bad(rxb[0]));
  hdc_link_model u_l1 (.i_clk, .i_tx_valid(txv[1]), .i_tx_data(txd[15:8]), .i_tx_eop(txe[1]), .i_tx_abort(txa[1]),
    .o_tx_ready(txr[1]), .o_rx_valid(rxv[1]), .o_rx_data(rxd[15:8]), .o_rx_sop(rxs[1]), .o_rx_eop(rxe[1]),
    .o_rx_bad(rxb[1]));
  initial forever #20 i_clk = ~i_clk;
  // hang guard, well above the length of the sequence
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // one strobe cycle; idle gap first so lagged fifo status has settled
  task automatic acc(input logic [7:0] pg, input logic [4:0] a, input logic w, input logic [7:0] d);
    repeat (2) @(negedge i_clk);
    i_cs = 1;
    i_page = pg;
    i_addr = a;
    i_wr = w;
    i_rd = !w;
    i_wdata = d;
    @(negedge i_clk);
    i_cs = 0;
    i_wr = 0;
    i_rd = 0;
    v = o_rdata;
  endtask : acc
  task automatic wr(input logic [7:0] pg, input logic [4:0] a, input logic [7:0] d);
    acc(pg, a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] pg, input logic [4:0] a);
    acc(pg, a, 1'b0, 8'h00);
  endtask : rd
  // three-byte packet through the filter, then drained with its byte codes
  task automatic pkt(input logic [7:0] a1, a2, c2, b1, b2, input logic ok, bad);
    wr(PAGE_FIRST, A_ADR1, a1);
    wr(PAGE_FIRST, A_ADR2, a2);
    wr(PAGE_FIRST, A_CTL2, c2);
    u_l0.send(b1, 1'b1, 1'b0, 1'b0);
    u_l0.send(b2, 1'b0, 1'b0, 1'b0);
    u_l0.send(8'h99, 1'b0, 1'b1, bad);
    rd(PAGE_FIRST, A_STAT);
    `CHK(v[0], !ok)
    if (ok) begin
      `CHK(v[5:4], RQ_FIRST)
      rd(PAGE_FIRST, A_FIFO);
      `CHK(v, b1)
      rd(PAGE_FIRST, A_STAT);
      `CHK(v[5:4], RQ_BODY)
      rd(PAGE_FIRST, A_FIFO);
      `CHK(v, b2)
      rd(PAGE_FIRST, A_STAT);
      `CHK(v[5:4], bad ? RQ_BAD : RQ_GOOD)
      rd(PAGE_FIRST, A_FIFO);
      `CHK(v, 8'h99)
    end
  endtask : pkt
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 0;
    // reset value, read back, and the other page left alone
    for (int k = 0; k < 6; k++) begin
      rd(PAGE_FIRST, ra[k]);
      `CHK(v, RST_REG)
      wr(PAGE_FIRST, ra[k], 8'h5a ^ 8'(k));
      rd(PAGE_FIRST, ra[k]);
      `CHK(v, 8'h5a ^ 8'(k))
      rd(PAGE_SECOND, ra[k]);
      `CHK(v, RST_REG)
    end
    // fill tx fifo with the transmitter off; the ninth byte is refused
    for (int k = 0; k < 9; k++) wr(PAGE_FIRST, A_FIFO, 8'h10 + 8'(k));
    rd(PAGE_FIRST, A_STAT);
    `CHK(v[3:2], 2'b10)
    wr(PAGE_FIRST, A_CTL1, 8'h20);
    repeat (200) if (u_l0.got.size() < 8) @(negedge i_clk);
    wr(PAGE_FIRST, A_CTL1, 8'h30);
    wr(PAGE_FIRST, A_FIFO, 8'h3c);
    rd(PAGE_FIRST, A_CTL1);
    `CHK(v, 8'h20)
    wr(PAGE_FIRST, A_CTL1, 8'h2c);
    wr(PAGE_FIRST, A_FIFO, 8'hc3);
    rd(PAGE_FIRST, A_CTL1);
    `CHK(v, 8'h24)
    repeat (60) @(negedge i_clk);
    `CHK(u_l0.got.size(), 10)
    for (int k = 0; k < 8; k++) `CHK(u_l0.got[k], {2'b00, 8'h10 + 8'(k)})
    `CHK(u_l0.got[8], {2'b01, 8'h3c})
    `CHK(u_l0.got[9], {2'b10, 8'hc3})
    rd(PAGE_FIRST, A_STAT);
    `CHK(v[2], 1'b1)
    wr(PAGE_SECOND, A_CTL1, 8'h24);
    wr(PAGE_SECOND, A_FIFO, 8'h77);
    repeat (20) @(negedge i_clk);
    `CHK(u_l1.got[0], {2'b00, 8'h77})
    // receive filter table
    wr(PAGE_FIRST, A_CTL1, 8'hc0);
    pkt(8'ha5, 8'h00, 8'h00, 8'ha4, 8'h33, 1, 0);
    pkt(8'ha5, 8'h00, 8'h00, 8'ha8, 8'h33, 0, 0);
    pkt(8'ha5, 8'h00, 8'h00, 8'ha6, 8'h33, 1, 1);
    pkt(8'ha5, 8'h00, 8'h10, 8'ha6, 8'h33, 0, 0);
    pkt(8'ha4, 8'h00, 8'h00, 8'h00, 8'h33, 1, 0);
    pkt(8'ha5, 8'h5b, 8'h00, 8'ha4, 8'h5a, 1, 0);
    pkt(8'ha5, 8'h5b, 8'h00, 8'ha4, 8'h5c, 0, 0);
    pkt(8'ha5, 8'h5b, 8'h00, 8'hfe, 8'hfe, 1, 0);
    rd(PAGE_FIRST, A_TSTA);
    `CHK(v, 8'h01)
    pkt(8'ha5, 8'h5a, 8'h00, 8'hfe, 8'h33, 0, 0);
    pkt(8'ha4, 8'h5b, 8'h00, 8'hfe, 8'h33, 0, 0);
    rd(PAGE_FIRST, A_TSTA);
    `CHK(v, 8'h00)
    wr(PAGE_FIRST, A_CTL1, 8'h40);
    pkt(8'ha5, 8'h5b, 8'h00, 8'h00, 8'h00, 1, 0);
    // go-ahead event, idle flag and interrupt flag
    wr(PAGE_FIRST, A_IMSK, 8'h80);
    rd(PAGE_FIRST, A_ISTA);
    idl = 2'b01;
    @(negedge i_clk);
    ga = 2'b01;
    und = 2'b01;
    @(negedge i_clk);
    ga = 2'b00;
    und = 2'b00;
    rd(PAGE_FIRST, A_STAT);
    `CHK(v[7:6], 2'b11)
    rd(PAGE_FIRST, A_ISTA);
    `CHK(v[IB_GA], 1'b1)
    `CHK(v[IB_ABUN], 1'b1)
    rd(PAGE_FIRST, A_ISTA);
    `CHK(v[IB_GA], 1'b0)
    `CHK(v[IB_ABUN], 1'b0)
    rd(PAGE_FIRST, A_STAT);
    `CHK(v[7], 1'b0)
    // check sequence bytes per page and unmapped offsets
    rd(PAGE_FIRST, A_CRCL);
    `CHK(v, 8'hcd)
    rd(PAGE_SECOND, A_CRCH);
    `CHK(v, 8'h12)
    rd(PAGE_FIRST, A_CRCH);
    `CHK(v, 8'hab)
    rd(PAGE_FIRST, 5'h05);
    `CHK(v, 8'h00)
    rd(PAGE_FIRST, 5'h1f);
    `CHK(v, 8'h00)
    test_done();
  end
endmodule : tb
`default_nettype wire
